// ==== hw/host_port_pkg.sv ====
// Constants, field positions and state codes of the dual-mode host port
package host_port_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam logic [6:0] PAGE_SEL_ADDR = 7'h7f;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [6:0] ADDR_RESET = 7'h00;
   localparam int DIR_BIT = 7;
   localparam int AINC_BIT = 7;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [1:0] DATA_BYTE = 2'h2;
   localparam logic [3:0] BYTE_DONE = 4'h8;
   localparam int CORE_CLK_KHZ = 200000;
   localparam int SPI_MAX_KBPS = 40000;
   localparam int I2C_STD_KBPS = 100;
   localparam int I2C_FAST_KBPS = 400;
   // Core cycles per bit at the top rates, rounded down
   localparam int SPI_BIT_CYC = CORE_CLK_KHZ / SPI_MAX_KBPS;
   localparam int I2C_BIT_CYC = CORE_CLK_KHZ / I2C_FAST_KBPS;
   // Positions in the synchroniser vector
   localparam int SY_STRAP = 0;
   localparam int SY_SCL = 1;
   localparam int SY_SDA = 2;
   localparam int SY_A0 = 3;
   localparam int SY_A1 = 4;
   localparam int SY_CMD = 5;
   localparam int SY_WR = 6;
   localparam int SY_LD = 7;
   localparam int SY_W = 8;
   typedef enum logic [6:0] {
      I_IDLE = 7'h01,
      I_DEV  = 7'h02,
      I_REG  = 7'h04,
      I_WR   = 7'h08,
      I_ACK  = 7'h10,
      I_RD   = 7'h20,
      I_MACK = 7'h40
   } i2c_state_e;
endpackage

// ==== hw/spi_link_shifter.sv ====
// SPI link side of the host port, clocked by the host serial clock
`timescale 1ns/10ps
module spi_link_shifter
   import host_port_pkg::*;
(
   input  wire logic       sclk_in,
   input  wire logic       frame_off_in,
   input  wire logic       rst_n_in,
   input  wire logic       sdi_in,
   input  wire logic [7:0] rd_byte_in,
   output logic [7:0]      cmd_byte_out,
   output logic            cmd_tog_out,
   output logic [7:0]      wr_byte_out,
   output logic            wr_tog_out,
   output logic            ld_tog_out,
   output logic            sdo_out,
   output logic            sdo_oe_n_out
);
   logic [2:0] bit_cnt;
   logic [1:0] byte_cnt;
   logic [6:0] shift_in;
   logic [7:0] out_sh;
   logic       byte_done;
   logic       load;
   logic [7:0] rx;
   logic [2:0] next_bit_cnt;
   logic [1:0] next_byte_cnt;
   logic [7:0] next_out_sh;
   logic       next_oe_n;

   always_comb begin
      rx = {shift_in, sdi_in};
      byte_done = (bit_cnt == LAST_BIT);
      next_bit_cnt = 3'(bit_cnt + 3'h1);
      next_byte_cnt = byte_cnt;
      if (byte_done && byte_cnt != DATA_BYTE) begin
         next_byte_cnt = 2'(byte_cnt + 2'h1);
      end
      // Read data goes out from the falling edge that closes the second byte and each data byte
      load = (bit_cnt == 3'h0) && (byte_cnt == DATA_BYTE) && cmd_byte_out[DIR_BIT];
      next_out_sh = load ? rd_byte_in : {out_sh[6:0], 1'b0};
      next_oe_n = load ? 1'b0 : sdo_oe_n_out;
   end

   // Frame counters restart whenever chip select rises
   always_ff @(posedge sclk_in or posedge frame_off_in) begin
      if (frame_off_in) begin
         bit_cnt <= 3'h0;
         byte_cnt <= 2'h0;
         shift_in <= 7'h00;
      end else begin
         bit_cnt <= next_bit_cnt;
         byte_cnt <= next_byte_cnt;
         shift_in <= rx[6:0];
      end
   end

   // Toggles survive frames so the core never sees a false event
   always_ff @(posedge sclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmd_byte_out <= 8'h00;
         cmd_tog_out <= 1'b0;
         wr_byte_out <= 8'h00;
         wr_tog_out <= 1'b0;
      end else begin
         if (byte_done && byte_cnt == 2'h0) begin
            cmd_byte_out <= rx;
            cmd_tog_out <= ~cmd_tog_out;
         end
         if (byte_done && byte_cnt == DATA_BYTE && !cmd_byte_out[DIR_BIT]) begin
            wr_byte_out <= rx;
            wr_tog_out <= ~wr_tog_out;
         end
      end
   end

   always_ff @(negedge sclk_in or posedge frame_off_in) begin
      if (frame_off_in) begin
         out_sh <= 8'h00;
         sdo_oe_n_out <= 1'b1;
      end else begin
         out_sh <= next_out_sh;
         sdo_oe_n_out <= next_oe_n;
      end
   end

   always_ff @(negedge sclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ld_tog_out <= 1'b0;
      end else begin
         ld_tog_out <= ld_tog_out ^ load;
      end
   end

   assign sdo_out = out_sh[7];

   a_no_early_write: assert property (@(posedge sclk_in) disable iff (frame_off_in)
      $changed(wr_tog_out) |-> $past(byte_cnt) == DATA_BYTE && !cmd_byte_out[DIR_BIT])
      else $error("write byte taken before the data phase");
   a_cmd_first_byte: assert property (@(posedge sclk_in) disable iff (frame_off_in)
      $changed(cmd_tog_out) |-> $past(byte_cnt) == 2'h0 && bit_cnt == 3'h0)
      else $error("command byte not taken at the end of byte zero");
endmodule

// ==== hw/host_port.sv ====
// Dual-mode host register port: SPI slave or I2C slave chosen by a strap
//
// Functional notes
// - Strap low: host port is a four-wire SPI slave with writes and reads.
// - SPI runs up to 40 Mbps; host never clocks faster.
// - Chip select high: serial input ignored, serial output high impedance.
// - SPI samples input on rising clock edges, changes output on falling.
// - Command byte MSB picks direction: 0 write, 1 read.
// - Low seven command bits give the starting register address.
// - Second byte is ignored; data bytes begin with the third.
// - SPI address increments after every data byte while select stays low.
// - Strap high: host port is a two-wire I2C interface.
// - In I2C the port is slave only and never drives clock.
// - I2C Standard mode to 100 kbps and Fast mode to 400 kbps.
// - I2C reuses clock pin as SCL, output as SDA, others as straps.
// - Slave address: five fixed upper bits, two low bits from straps.
// - After slave address comes register address byte with increment bit.
// - With increment on, address advances after each data byte.
// - Read without address byte continues at the last used address.
// - Random reads work with increment enabled or disabled.
// - Page selector answers at the same address on every page.
`timescale 1ns/10ps
module host_port
   import host_port_pkg::*;
#(
   // Fixed upper slave address bits; value arbitrary
   parameter logic [4:0] SLAVE_ADDR_HI = 5'h10
)
(
   input  wire logic       core_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       host_protocol_strap_in,
   input  wire logic       host_serial_clock_in,
   input  wire logic       host_cs_n_in,
   input  wire logic       host_serial_in_in,
   input  wire logic       host_serial_out_in,
   output logic            host_serial_out_out,
   output logic            host_serial_out_oe_n_out,
   output logic [6:0]      reg_addr_out,
   output logic [7:0]      reg_wdata_out,
   output logic            reg_wr_out,
   output logic            reg_rd_out,
   input  wire logic [7:0] reg_rdata_in,
   output logic [7:0]      page_out
);
   logic [7:0]      cmd_byte;
   logic            cmd_tog;
   logic [7:0]      wr_byte;
   logic            wr_tog;
   logic            ld_tog;
   logic            spi_sdo;
   logic            spi_oe_n;
   logic            frame_off;
   logic [SY_W-1:0] raw;
   logic [SY_W-1:0] sync1;
   logic [SY_W-1:0] sync2;
   logic [SY_W-1:0] prev;
   logic            spi_mode;
   logic            cmd_ev;
   logic            wr_ev;
   logic            ld_ev;
   logic            scl_rise;
   logic            scl_fall;
   logic            start_ev;
   logic            stop_ev;
   logic [6:0]      my_addr;
   logic [6:0]      addr;
   logic [7:0]      hold;
   logic            inc_en;
   i2c_state_e      ist;
   i2c_state_e      after;
   logic [3:0]      cnt;
   logic [7:0]      sh;
   logic            i2c_oe_n;
   logic [6:0]      next_addr;
   logic [6:0]      next_port_addr;
   logic [7:0]      next_page;
   logic [7:0]      next_hold;
   logic            next_inc_en;
   logic            next_rd;
   logic            next_wr;
   logic [7:0]      next_wdata;
   i2c_state_e      next_ist;
   i2c_state_e      next_after;
   logic [3:0]      next_cnt;
   logic [7:0]      next_sh;
   logic            next_i2c_oe_n;
   logic            do_wr;
   logic [7:0]      wr_val;
   logic            do_fetch;
   logic [6:0]      fetch_addr;

   function automatic logic flipped(input logic now, input logic was);
      return now ^ was;
   endfunction

   // SPI logic is held idle in I2C mode, where the select pin is a strap
   assign frame_off = host_cs_n_in | host_protocol_strap_in;

   spi_link_shifter link (
      .sclk_in      (host_serial_clock_in),
      .frame_off_in (frame_off),
      .rst_n_in     (rst_n_in),
      .sdi_in       (host_serial_in_in),
      .rd_byte_in   (hold),
      .cmd_byte_out (cmd_byte),
      .cmd_tog_out  (cmd_tog),
      .wr_byte_out  (wr_byte),
      .wr_tog_out   (wr_tog),
      .ld_tog_out   (ld_tog),
      .sdo_out      (spi_sdo),
      .sdo_oe_n_out (spi_oe_n)
   );

   // Pins and link toggles enter the core through two flops
   // Toggles never merge: link bytes come at least 8 * SPI_BIT_CYC core cycles apart
   always_comb begin
      raw = '0;
      raw[SY_STRAP] = host_protocol_strap_in;
      raw[SY_SCL] = host_serial_clock_in;
      raw[SY_SDA] = host_serial_out_in;
      raw[SY_A0] = host_cs_n_in;
      raw[SY_A1] = host_serial_in_in;
      raw[SY_CMD] = cmd_tog;
      raw[SY_WR] = wr_tog;
      raw[SY_LD] = ld_tog;
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   always_comb begin
      spi_mode = !sync2[SY_STRAP];
      cmd_ev = spi_mode && flipped(sync2[SY_CMD], prev[SY_CMD]);
      wr_ev = spi_mode && flipped(sync2[SY_WR], prev[SY_WR]);
      ld_ev = spi_mode && flipped(sync2[SY_LD], prev[SY_LD]);
      // SCL is oversampled; 200 MHz is far above the 400 kHz Fast mode rate
      scl_rise = sync2[SY_SCL] && !prev[SY_SCL];
      scl_fall = !sync2[SY_SCL] && prev[SY_SCL];
      start_ev = sync2[SY_SCL] && prev[SY_SCL] && prev[SY_SDA] && !sync2[SY_SDA];
      stop_ev = sync2[SY_SCL] && prev[SY_SCL] && !prev[SY_SDA] && sync2[SY_SDA];
      my_addr = {SLAVE_ADDR_HI, sync2[SY_A1], sync2[SY_A0]};
   end

   always_comb begin
      next_addr = addr;
      next_port_addr = reg_addr_out;
      next_page = page_out;
      next_hold = hold;
      next_inc_en = inc_en;
      next_wr = 1'b0;
      next_wdata = reg_wdata_out;
      next_ist = ist;
      next_after = after;
      next_cnt = cnt;
      next_sh = sh;
      next_i2c_oe_n = i2c_oe_n;
      do_wr = 1'b0;
      wr_val = 8'h00;
      do_fetch = 1'b0;
      fetch_addr = addr;
      if (spi_mode) begin
         next_ist = I_IDLE;
         next_i2c_oe_n = 1'b1;
         if (cmd_ev) begin
            next_addr = cmd_byte[ADDR_W-1:0];
            // Reads prefetch during the ignored second byte
            do_fetch = cmd_byte[DIR_BIT];
            fetch_addr = cmd_byte[ADDR_W-1:0];
         end
         if (wr_ev) begin
            do_wr = 1'b1;
            wr_val = wr_byte;
            next_addr = 7'(addr + 7'h1);
         end
         if (ld_ev) begin
            next_addr = 7'(addr + 7'h1);
            do_fetch = 1'b1;
            fetch_addr = 7'(addr + 7'h1);
         end
      end else if (start_ev) begin
         next_ist = I_DEV;
         next_cnt = 4'h0;
         next_i2c_oe_n = 1'b1;
      end else if (stop_ev) begin
         next_ist = I_IDLE;
         next_i2c_oe_n = 1'b1;
      end else if (scl_rise) begin
         if (ist == I_DEV || ist == I_REG || ist == I_WR) begin
            next_sh = {sh[6:0], sync2[SY_SDA]};
            next_cnt = 4'(cnt + 4'h1);
         end
         if (ist == I_MACK && sync2[SY_SDA]) begin
            next_ist = I_IDLE;
         end
      end else if (scl_fall) begin
         case (ist)
            I_DEV, I_REG, I_WR: begin
               if (cnt == BYTE_DONE) begin
                  next_ist = I_ACK;
                  next_i2c_oe_n = 1'b0;
                  next_after = I_WR;
                  if (ist == I_DEV) begin
                     if (sh[7:1] != my_addr) begin
                        next_ist = I_IDLE;
                        next_i2c_oe_n = 1'b1;
                     end else if (sh[0]) begin
                        // Read with no address byte resumes at the last address
                        next_after = I_RD;
                        do_fetch = 1'b1;
                     end else begin
                        next_after = I_REG;
                     end
                  end else if (ist == I_REG) begin
                     next_addr = sh[ADDR_W-1:0];
                     next_inc_en = sh[AINC_BIT];
                  end else begin
                     do_wr = 1'b1;
                     wr_val = sh;
                     if (inc_en) begin
                        next_addr = 7'(addr + 7'h1);
                     end
                  end
               end
            end
            I_ACK: begin
               next_ist = after;
               next_cnt = 4'h0;
               next_i2c_oe_n = 1'b1;
               if (after == I_RD) begin
                  next_sh = hold;
                  next_i2c_oe_n = hold[7];
                  next_cnt = 4'h1;
               end
            end
            I_RD: begin
               if (cnt == BYTE_DONE) begin
                  next_ist = I_MACK;
                  next_i2c_oe_n = 1'b1;
                  do_fetch = 1'b1;
                  // Without increment the same register is read again
                  if (inc_en) begin
                     next_addr = 7'(addr + 7'h1);
                     fetch_addr = 7'(addr + 7'h1);
                  end
               end else begin
                  next_sh = {sh[6:0], 1'b1};
                  next_i2c_oe_n = sh[6];
                  next_cnt = 4'(cnt + 4'h1);
               end
            end
            I_MACK: begin
               next_ist = I_RD;
               next_sh = hold;
               next_i2c_oe_n = hold[7];
               next_cnt = 4'h1;
            end
            default: begin
               next_ist = I_IDLE;
            end
         endcase
      end
      // Page selector is kept here so every page reaches it
      if (do_wr) begin
         if (addr == PAGE_SEL_ADDR) begin
            next_page = wr_val;
         end else begin
            next_wr = 1'b1;
            next_wdata = wr_val;
            next_port_addr = addr;
         end
      end
      next_rd = do_fetch;
      if (do_fetch) begin
         next_port_addr = fetch_addr;
      end
      // Fetch data is taken while the read strobe stands
      if (reg_rd_out) begin
         next_hold = (reg_addr_out == PAGE_SEL_ADDR) ? page_out : reg_rdata_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         addr <= ADDR_RESET;
         reg_addr_out <= ADDR_RESET;
         page_out <= PAGE_RESET;
         hold <= 8'h00;
         inc_en <= 1'b0;
         reg_rd_out <= 1'b0;
         reg_wr_out <= 1'b0;
         reg_wdata_out <= 8'h00;
         ist <= I_IDLE;
         after <= I_IDLE;
         cnt <= 4'h0;
         sh <= 8'h00;
         i2c_oe_n <= 1'b1;
      end else begin
         addr <= next_addr;
         reg_addr_out <= next_port_addr;
         page_out <= next_page;
         hold <= next_hold;
         inc_en <= next_inc_en;
         reg_rd_out <= next_rd;
         reg_wr_out <= next_wr;
         reg_wdata_out <= next_wdata;
         ist <= next_ist;
         after <= next_after;
         cnt <= next_cnt;
         sh <= next_sh;
         i2c_oe_n <= next_i2c_oe_n;
      end
   end

   // Static strap picks the pin owner; SDA only ever pulls low
   always_comb begin
      host_serial_out_out = spi_mode ? spi_sdo : 1'b0;
      host_serial_out_oe_n_out = spi_mode ? spi_oe_n : i2c_oe_n;
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_spi_cmd_addr: assert property (cmd_ev |=> addr == $past(cmd_byte[6:0]))
      else $error("SPI start address not taken from command");
   a_spi_read_fetch: assert property (cmd_ev && cmd_byte[7]
      |=> reg_rd_out && reg_addr_out == $past(cmd_byte[6:0]))
      else $error("SPI read did not fetch the command address");
   a_spi_write_dir: assert property (cmd_ev && !cmd_byte[7] |=> !reg_rd_out)
      else $error("SPI write command caused a read");
   a_spi_autoinc: assert property (wr_ev |=> addr == 7'($past(addr) + 7'h1) ##1
      !reg_wr_out || reg_addr_out != addr)
      else $error("SPI address did not advance after a data byte");
   a_page_hidden: assert property (reg_wr_out |-> reg_addr_out != PAGE_SEL_ADDR)
      else $error("page selector write leaked to register port");
   a_i2c_no_match: assert property (ist == I_DEV && scl_fall && cnt == BYTE_DONE
      && sh[7:1] != my_addr && !spi_mode |=> ist == I_IDLE && i2c_oe_n)
      else $error("I2C answered a foreign slave address");
   a_i2c_slave_only: assert property (!spi_mode |-> !host_serial_out_out
      && (!$changed(i2c_oe_n) || !$past(sync2[SY_SCL])))
      else $error("I2C data pin driven high or moved while the clock was high");
   a_i2c_inc: assert property (!spi_mode && ist == I_WR && scl_fall && cnt == BYTE_DONE
      && inc_en |=> addr == 7'($past(addr) + 7'h1)
      && (reg_wr_out || $past(addr) == PAGE_SEL_ADDR))
      else $error("I2C increment missing after a data byte");
   a_i2c_no_inc: assert property (!spi_mode && ist == I_RD && scl_fall
      && cnt == BYTE_DONE && !inc_en |=> $stable(addr) && reg_rd_out)
      else $error("I2C address moved with increment disabled");
endmodule

// ==== bench/host_master.sv ====
// Host controller model: SPI master and I2C master on the shared host pins
`timescale 1ns/10ps
module host_master (
   input  wire logic miso_in,
   input  wire logic sda_in,
   output logic      clk_out,
   output logic      cs_n_out,
   output logic      mosi_out,
   output logic      sda_n_out
);
   localparam realtime SPI_HALF = 62.5;
   localparam realtime I2C_Q = 625.0;
   logic [7:0] tx_buf [8];
   logic [7:0] rx_buf [8];
   logic       ack;

   // A real select edge pulls the link flops out of their unknown start
   initial begin
      clk_out = 1'b0;
      cs_n_out = 1'b0;
      mosi_out = 1'b0;
      sda_n_out = 1'b1;
      #1 cs_n_out = 1'b1;
   end

   // Clock only moves inside a frame
   task automatic spi_frame(input int n);
      cs_n_out <= 1'b0;
      #SPI_HALF;
      for (int i = 0; i < n; i++) begin
         for (int b = 7; b >= 0; b--) begin
            mosi_out <= tx_buf[i][b];
            #SPI_HALF;
            clk_out <= 1'b1;
            rx_buf[i][b] = miso_in;
            #SPI_HALF;
            clk_out <= 1'b0;
         end
      end
      #SPI_HALF;
      cs_n_out <= 1'b1;
      mosi_out <= ~mosi_out;
      #(4 * SPI_HALF);
   endtask

   // Select and serial input pins become the address straps
   task automatic i2c_mode(input logic a1, input logic a0);
      clk_out <= 1'b1;
      cs_n_out <= a0;
      mosi_out <= a1;
   endtask

   // Also serves as repeated start when SCL is low
   task automatic i2c_start();
      sda_n_out <= 1'b1;
      #I2C_Q clk_out <= 1'b1;
      #I2C_Q sda_n_out <= 1'b0;
      #I2C_Q clk_out <= 1'b0;
   endtask

   task automatic i2c_bit(input logic v, output logic s);
      #I2C_Q sda_n_out <= v;
      #I2C_Q clk_out <= 1'b1;
      #I2C_Q s = sda_in;
      #I2C_Q clk_out <= 1'b0;
   endtask

   // Ninth bit: master drives mack, slave answer lands in ack
   task automatic i2c_byte(input logic [7:0] v, input logic mack, output logic [7:0] r);
      logic s;
      for (int b = 7; b >= 0; b--) begin
         i2c_bit(v[b], s);
         r[b] = s;
      end
      i2c_bit(mack, ack);
   endtask

   task automatic i2c_stop();
      #I2C_Q sda_n_out <= 1'b0;
      #I2C_Q clk_out <= 1'b1;
      #I2C_Q sda_n_out <= 1'b1;
      #I2C_Q;
   endtask
endmodule

// ==== bench/tb_dual_mode_host_register_port.sv ====
// Self-checking bench of the host port in both protocol modes
`timescale 1ns/10ps
module tb_dual_mode_host_register_port;
   localparam int TMO = 98000;
   logic       core_clk_in;
   logic       rst_n_in;
   logic       strap;
   logic       clk_w;
   logic       cs_w;
   logic       mosi_w;
   logic       sda_n_w;
   logic       sda_w;
   logic       sdo;
   logic       sdo_oe_n;
   logic       miso_w;
   logic [6:0] reg_addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] page;
   logic [7:0] r;
   logic       wr;
   logic       rd;
   logic [7:0] mem [128];
   int         num_errors;
   int         n_tests;
   int         wr_count;
   int         cycles;

   // Open-drain SDA with pull-up
   assign sda_w = sda_n_w & (sdo_oe_n | sdo);
   // Undriven serial output shows the inverse so high impedance is caught
   assign miso_w = sdo_oe_n ? ~sdo : sdo;
   // Data is only good while the read strobe stands
   assign rdata = rd ? mem[reg_addr] : ~mem[reg_addr];

   host_port uut (
      .core_clk_in              (core_clk_in),
      .rst_n_in                 (rst_n_in),
      .host_protocol_strap_in   (strap),
      .host_serial_clock_in     (clk_w),
      .host_cs_n_in             (cs_w),
      .host_serial_in_in        (mosi_w),
      .host_serial_out_in       (sda_w),
      .host_serial_out_out      (sdo),
      .host_serial_out_oe_n_out (sdo_oe_n),
      .reg_addr_out             (reg_addr),
      .reg_wdata_out            (wdata),
      .reg_wr_out               (wr),
      .reg_rd_out               (rd),
      .reg_rdata_in             (rdata),
      .page_out                 (page)
   );

   host_master host (
      .miso_in   (miso_w),
      .sda_in    (sda_w),
      .clk_out   (clk_w),
      .cs_n_out  (cs_w),
      .mosi_out  (mosi_w),
      .sda_n_out (sda_n_w)
   );

   function automatic logic [7:0] init_val(input int a);
      return 8'(a) ^ 8'h5a;
   endfunction

   initial begin
      core_clk_in = 1'b0;
      // Starts high so the link's asynchronous clear sees a true falling edge
      rst_n_in = 1'b1;
      strap = 1'b0;
      num_errors = 0;
      n_tests = 0;
      wr_count = 0;
      cycles = 0;
      for (int i = 0; i < 128; i++) begin
         mem[i] = init_val(i);
      end
   end

   always #2.5 core_clk_in = ~core_clk_in;

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Register file and watchdog
   always @(posedge core_clk_in) begin
      cycles <= cycles + 1;
      if (wr === 1'b1) begin
         mem[reg_addr] <= wdata;
         wr_count <= wr_count + 1;
      end
      if (cycles == TMO) begin
         num_errors++;
         $display("Error at %0t: timeout", $time);
         results();
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic do_reset(input logic s);
      @(posedge core_clk_in);
      rst_n_in <= 1'b0;
      strap <= s;
      repeat (10) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      repeat (5) @(posedge core_clk_in);
      chk8(page, 8'h00);
      chk1(sdo_oe_n, 1'b1);
   endtask

   // Start near the top: crosses the page selector and wraps to zero
   task automatic t_spi_write();
      int c0;
      c0 = wr_count;
      host.tx_buf[0] = 8'h7e;
      host.tx_buf[1] = 8'hc3;
      host.tx_buf[2] = 8'ha1;
      host.tx_buf[3] = 8'h02;
      host.tx_buf[4] = 8'h3c;
      host.spi_frame(5);
      chk8(mem[8'h7e], 8'ha1);
      chk8(page, 8'h02);
      chk8(mem[0], 8'h3c);
      chk8(8'(wr_count - c0), 8'h02);
   endtask

   task automatic t_spi_read();
      int c0;
      c0 = wr_count;
      host.tx_buf[0] = 8'h90;
      host.tx_buf[1] = 8'h00;
      host.tx_buf[2] = 8'hff;
      host.tx_buf[3] = 8'hff;
      host.tx_buf[4] = 8'hff;
      host.spi_frame(5);
      chk8(host.rx_buf[2], init_val(8'h10));
      chk8(host.rx_buf[3], init_val(8'h11));
      chk8(host.rx_buf[4], init_val(8'h12));
      chk8(8'(wr_count - c0), 8'h00);
      chk1(sdo_oe_n, 1'b1);
      host.tx_buf[0] = 8'hff;
      host.spi_frame(3);
      chk8(host.rx_buf[2], 8'h02);
      chk1(sdo_oe_n, 1'b1);
   endtask

   task automatic t_i2c_addr();
      host.i2c_start();
      host.i2c_byte(8'h86, 1'b1, r);
      chk1(host.ack, 1'b1);
      host.i2c_stop();
   endtask

   task automatic t_i2c_write();
      host.i2c_start();
      host.i2c_byte(8'h84, 1'b1, r);
      chk1(host.ack, 1'b0);
      host.i2c_byte(8'ha0, 1'b1, r);
      chk1(host.ack, 1'b0);
      host.i2c_byte(8'h11, 1'b1, r);
      host.i2c_byte(8'h22, 1'b1, r);
      chk1(host.ack, 1'b0);
      host.i2c_stop();
      chk8(mem[8'h20], 8'h11);
      chk8(mem[8'h21], 8'h22);
   endtask

   task automatic t_i2c_read(input logic [7:0] rb, input logic [7:0] e0, input logic [7:0] e1);
      host.i2c_start();
      host.i2c_byte(8'h84, 1'b1, r);
      host.i2c_byte(rb, 1'b1, r);
      host.i2c_start();
      host.i2c_byte(8'h85, 1'b1, r);
      host.i2c_byte(8'hff, 1'b0, r);
      chk8(r, e0);
      host.i2c_byte(8'hff, 1'b1, r);
      chk8(r, e1);
      host.i2c_stop();
   endtask

   task automatic t_i2c_current();
      host.i2c_start();
      host.i2c_byte(8'h85, 1'b1, r);
      host.i2c_byte(8'hff, 1'b1, r);
      chk8(r, 8'h22);
      host.i2c_stop();
   endtask

   initial begin
      do_reset(1'b0);
      t_spi_write();
      t_spi_read();
      host.i2c_mode(1'b1, 1'b0);
      do_reset(1'b1);
      t_i2c_addr();
      t_i2c_write();
      t_i2c_read(8'h21, 8'h22, 8'h22);
      t_i2c_current();
      t_i2c_read(8'ha0, 8'h11, 8'h22);
      results();
   end
endmodule
